// file: hw/pbmc_pkg.sv
// Types shared by the basic mode control block
package pbmc_pkg;

    typedef enum logic [0:0] {
        PBMC_RUN   = 1'b0,
        PBMC_SWRST = 1'b1
    } pbmc_phase_e;

    typedef struct packed {
        logic       en;
        logic [3:0] data;
    } pbmc_mii_s;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic aneg_enable;
        logic aneg_restart;
        logic power_down;
        logic isolate;
        logic loopback;
        logic core_reset;
    } pbmc_mode_s;

    typedef struct packed {
        pbmc_phase_e phase;
        logic [3:0]  rst_cnt;
        logic [13:0] dead_cnt;
        logic [15:0] ctl;
        logic [3:0]  pin_meta;
        logic [3:0]  pin_sync;
        logic        lh_fault;
        logic        ll_link;
        logic        jabber;
        logic [7:0]  fcs_cnt;
        logic [15:0] rdata;
        logic        rvalid;
        pbmc_mode_s  mode;
        pbmc_mii_s   rx;
        logic        col;
        logic        oe;
    } pbmc_state_s;

endpackage

// file: hw/pbmc_regs.svh
// Register map, field positions and timing constants of the basic mode control block
// Behaviour
// RULE1: Reset bit starts reset, reads one, self-clears
// RULE2: Software reset reloads all strap-derived settings
// RULE3: Loopback bit routes MII transmit to receive
// RULE4: Loopback start may blank receive data 500us
// RULE5: Speed bit forces 100 or 10 Mb/s
// RULE6: Auto-negotiation enable overrides speed and duplex bits
// RULE7: Auto-negotiation enable resets from its strap
// RULE8: Power down stops transceiver, registers stay alive
// RULE9: Power down is bit OR pin; pin sets bit
// RULE10: Isolate disconnects MII, management still works
// RULE11: Self-clearing status follows its event
// RULE12: Clear-on-read field clears after being read
// RULE13: Permanent read-only bits keep fixed value
// RULE14: Latched-low bit holds zero until read
// RULE15: Latched-high bit holds one until read
// RULE16: Duplex bit forces full or half duplex
// RULE17: Restart bit restarts negotiation, then self-clears
// RULE18: Collision test echoes transmit enable on COL
// RULE19: Low seven reserved bits read zero
// RULE20: Control word applied when write completes
`ifndef PBMC_REGS_SVH
`define PBMC_REGS_SVH

`define PBMC_ADDR_CTL      5'h00
`define PBMC_ADDR_STAT     5'h01
`define PBMC_ADDR_FCS      5'h14

`define PBMC_BIT_RESET     15
`define PBMC_BIT_LOOP      14
`define PBMC_BIT_SPEED     13
`define PBMC_BIT_ANEG      12
`define PBMC_BIT_PDOWN     11
`define PBMC_BIT_ISOLATE   10
`define PBMC_BIT_RESTART   9
`define PBMC_BIT_DUPLEX    8
`define PBMC_BIT_COLTEST   7

`define PBMC_CTL_WMASK     16'h7D80
`define PBMC_CTL_RMASK     16'h7F80
`define PBMC_CTL_RESET     16'h0000
`define PBMC_STAT_FIXED    16'h7840
`define PBMC_SB_FAULT      4
`define PBMC_SB_LINK       2
`define PBMC_SB_JABBER     1

`define PBMC_STRAP_ANEG    3
`define PBMC_STRAP_SPEED   2
`define PBMC_STRAP_DUPLEX  1
`define PBMC_STRAP_PDN     0

`define PBMC_RST_CYCLES    4'h8
`define PBMC_DEAD_US       500
`define PBMC_CLK_MHZ       25
`define PBMC_FCS_MAX       8'hFF

`endif

// file: hw/pbmc_top.sv
// Basic mode control register with strap reload, loopback and MII gating
`timescale 1ns/10ps
`include "pbmc_regs.svh"

module pbmc_top #(
    parameter int DEAD_CYCLES = `PBMC_DEAD_US * `PBMC_CLK_MHZ
) (
    input  wire logic          clock,
    input  wire logic          nrst,
    input  wire logic [4:0]    reg_addr,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [15:0]        reg_rdata,
    output logic               reg_rvalid,
    input  wire logic          strap_aneg,
    input  wire logic          strap_speed,
    input  wire logic          strap_duplex,
    input  wire logic          power_down_or_irq_pin_n,
    input  wire logic          an_speed_100,
    input  wire logic          an_full_duplex,
    input  wire logic          link_ok,
    input  wire logic          remote_fault,
    input  wire logic          jabber,
    input  wire logic          false_carrier,
    input  pbmc_pkg::pbmc_mii_s mii_tx,
    input  pbmc_pkg::pbmc_mii_s line_rx,
    input  wire logic          line_col,
    output pbmc_pkg::pbmc_mii_s mii_rx,
    output logic               mii_col,
    output logic               mii_oe,
    output pbmc_pkg::pbmc_mode_s mode
);
    import pbmc_pkg::*;

    localparam logic [13:0] DEAD_LOAD = 14'(DEAD_CYCLES);

    pbmc_state_s s;
    pbmc_state_s next_s;

    // Set wins over the read that would release it
    function automatic logic latch_high(input logic cur, input logic ev, input logic rd);
        latch_high = rd ? ev : (cur | ev);
    endfunction

    function automatic logic latch_low(input logic cur, input logic lvl, input logic rd);
        latch_low = rd ? lvl : (cur & lvl);
    endfunction

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    // Reset bit reads from the sequencer rather than from storage
    function automatic logic [15:0] ctl_view(input logic [15:0] ctl, input logic busy);
        logic [15:0] v;
        v = ctl & `PBMC_CTL_RMASK; // RULE19
        v[`PBMC_BIT_RESET] = busy; // RULE1
        ctl_view = v;
    endfunction

    // Straps come from the synchroniser, never from the raw pins
    function automatic logic [15:0] strap_word(input logic [3:0] pins);
        logic [15:0] v;
        v = `PBMC_CTL_RESET;
        v[`PBMC_BIT_ANEG] = pins[`PBMC_STRAP_ANEG]; // RULE7
        v[`PBMC_BIT_SPEED] = pins[`PBMC_STRAP_SPEED]; // RULE2
        v[`PBMC_BIT_DUPLEX] = pins[`PBMC_STRAP_DUPLEX]; // RULE2
        strap_word = v;
    endfunction

    // Restart is only kept when the same word enables negotiation
    function automatic logic [15:0] ctl_write(input logic [15:0] wdata);
        logic [15:0] v;
        v = wdata & `PBMC_CTL_WMASK; // RULE19
        v[`PBMC_BIT_RESTART] = wdata[`PBMC_BIT_RESTART] & wdata[`PBMC_BIT_ANEG]; // RULE17
        ctl_write = v;
    endfunction

    // Two live latches and the jabber bit merged over the fixed capability bits
    function automatic logic [15:0] stat_pack(input logic fault, input logic link,
        input logic jab);
        logic [15:0] v;
        v = `PBMC_STAT_FIXED; // RULE13
        v[`PBMC_SB_FAULT] = fault;
        v[`PBMC_SB_LINK] = link;
        v[`PBMC_SB_JABBER] = jab;
        stat_pack = v;
    endfunction

    // Dead time restarts only on the rising edge of loopback
    function automatic logic [13:0] dead_step(input logic [13:0] cnt, input logic loop_was,
        input logic loop_now);
        logic [13:0] v;
        v = cnt;
        if (!loop_now)
        begin
            v = 14'h0000;
        end
        else if (!loop_was)
        begin
            v = DEAD_LOAD; // RULE4
        end
        else if (cnt != 14'h0000)
        begin
            v = cnt - 14'h0001;
        end
        dead_step = v;
    endfunction

    // Receive enable stays low until the dead time has run out
    function automatic pbmc_mii_s loop_path(input pbmc_mii_s tx, input logic [13:0] cnt);
        pbmc_mii_s v;
        v.data = tx.data;
        v.en = tx.en && (cnt == 14'h0000); // RULE4
        loop_path = v;
    endfunction

    // Collision test echoes transmit enable in place of the line
    function automatic logic col_path(input logic test, input logic tx_en, input logic line);
        col_path = test ? tx_en : line; // RULE18
    endfunction

    // Forced bits only take effect while negotiation is off
    function automatic pbmc_mode_s mode_pack(input logic [15:0] ctl, input logic an_100,
        input logic an_fd, input logic pin_pd, input logic busy, input logic restart);
        pbmc_mode_s v;
        v = '0;
        v.aneg_enable = ctl[`PBMC_BIT_ANEG];
        if (ctl[`PBMC_BIT_ANEG]) // RULE6
        begin
            v.speed_100 = an_100;
            v.full_duplex = an_fd;
        end
        else
        begin
            v.speed_100 = ctl[`PBMC_BIT_SPEED]; // RULE5
            v.full_duplex = ctl[`PBMC_BIT_DUPLEX]; // RULE16
        end
        v.power_down = ctl[`PBMC_BIT_PDOWN] | pin_pd; // RULE8 RULE9
        v.isolate = ctl[`PBMC_BIT_ISOLATE]; // RULE10
        v.loopback = ctl[`PBMC_BIT_LOOP];
        v.aneg_restart = restart; // RULE17
        v.core_reset = busy; // RULE1
        mode_pack = v;
    endfunction

    logic        rd_stat;
    logic        rd_fcs;
    logic        wr_ctl;
    logic        pd_pin;
    logic        quiet;
    logic [15:0] stat_word;

    always_comb
    begin
        next_s = s;
        rd_stat = reg_rd && hit(reg_addr, `PBMC_ADDR_STAT);
        rd_fcs = reg_rd && hit(reg_addr, `PBMC_ADDR_FCS);
        wr_ctl = reg_wr && hit(reg_addr, `PBMC_ADDR_CTL);
        pd_pin = !s.pin_sync[`PBMC_STRAP_PDN];

        // Pins are asynchronous; only the second stage is looked at
        next_s.pin_meta = {strap_aneg, strap_speed, strap_duplex, power_down_or_irq_pin_n};
        next_s.pin_sync = s.pin_meta;

        next_s.lh_fault = latch_high(s.lh_fault, remote_fault, rd_stat); // RULE15
        next_s.ll_link = latch_low(s.ll_link, link_ok, rd_stat); // RULE14
        next_s.jabber = jabber; // RULE11

        // Count saturates so a slow reader still sees a full scale value
        if (rd_fcs) // RULE12
        begin
            next_s.fcs_cnt = {7'h00, false_carrier};
        end
        else if (false_carrier && s.fcs_cnt != `PBMC_FCS_MAX)
        begin
            next_s.fcs_cnt = s.fcs_cnt + 8'h01;
        end

        stat_word = stat_pack(s.lh_fault, s.ll_link, s.jabber); // RULE13

        next_s.rvalid = reg_rd;
        next_s.rdata = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `PBMC_ADDR_CTL:
                begin
                    next_s.rdata = ctl_view(s.ctl, s.phase == PBMC_SWRST); // RULE1 RULE19
                end
                `PBMC_ADDR_STAT:
                begin
                    next_s.rdata = stat_word;
                end
                `PBMC_ADDR_FCS:
                begin
                    next_s.rdata = {8'h00, s.fcs_cnt};
                end
                default:
                begin
                    next_s.rdata = 16'h0000;
                end
            endcase
        end

        // Restart is taken by negotiation one cycle after it is written
        next_s.mode.aneg_restart = 1'b0;
        if (s.ctl[`PBMC_BIT_RESTART]) // RULE17
        begin
            next_s.ctl[`PBMC_BIT_RESTART] = 1'b0;
            next_s.mode.aneg_restart = s.ctl[`PBMC_BIT_ANEG];
        end

        unique case (s.phase)
            PBMC_RUN:
            begin
                if (wr_ctl) // RULE20
                begin
                    if (reg_wdata[`PBMC_BIT_RESET]) // RULE1
                    begin
                        next_s.phase = PBMC_SWRST;
                        next_s.rst_cnt = `PBMC_RST_CYCLES;
                    end
                    else
                    begin
                        next_s.ctl = ctl_write(reg_wdata); // RULE17 RULE19
                    end
                end
            end
            PBMC_SWRST:
            begin
                // Writes are dropped while the core is held in reset
                if (s.rst_cnt == 4'h0)
                begin
                    next_s.phase = PBMC_RUN;
                    next_s.ctl = strap_word(s.pin_sync); // RULE2 RULE7
                end
                else
                begin
                    next_s.rst_cnt = s.rst_cnt - 4'h1;
                end
            end
        endcase

        if (pd_pin) // RULE9
        begin
            next_s.ctl[`PBMC_BIT_PDOWN] = 1'b1;
        end

        // Dead time models descrambler relock when loopback turns on
        next_s.dead_cnt = dead_step(s.dead_cnt, s.ctl[`PBMC_BIT_LOOP],
            next_s.ctl[`PBMC_BIT_LOOP]); // RULE4

        next_s.mode = mode_pack(s.ctl, an_speed_100, an_full_duplex, pd_pin,
            s.phase == PBMC_SWRST, next_s.mode.aneg_restart); // RULE5 RULE6 RULE16

        // Register block stays reachable whatever the data path does
        quiet = s.ctl[`PBMC_BIT_ISOLATE] | s.ctl[`PBMC_BIT_PDOWN] | pd_pin
            | (s.phase == PBMC_SWRST);
        next_s.oe = !s.ctl[`PBMC_BIT_ISOLATE]; // RULE10
        if (quiet) // RULE8 RULE10
        begin
            next_s.rx = '0;
            next_s.col = 1'b0;
        end
        else if (s.ctl[`PBMC_BIT_LOOP]) // RULE3
        begin
            next_s.rx = loop_path(mii_tx, s.dead_cnt); // RULE3 RULE4
            next_s.col = col_path(s.ctl[`PBMC_BIT_COLTEST], mii_tx.en, 1'b0); // RULE18
        end
        else
        begin
            next_s.rx = line_rx;
            next_s.col = col_path(s.ctl[`PBMC_BIT_COLTEST], mii_tx.en, line_col); // RULE18
        end
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            // Power-on runs the same sequence as a software reset
            s <= '0;
            s.phase <= PBMC_SWRST;
            s.rst_cnt <= `PBMC_RST_CYCLES;
            s.pin_meta <= 4'h1;
            s.pin_sync <= 4'h1;
            s.ll_link <= 1'b0;
            s.mode.core_reset <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign mii_rx = s.rx;
    assign mii_col = s.col;
    assign mii_oe = s.oe;
    assign mode = s.mode;

endmodule // pbmc_top

// file: verif/pbmc_assertions.sv
// Port checker for the basic mode control block
`timescale 1ns/10ps
module pbmc_checker #(
    parameter int DEAD_CYCLES = 12500
) (
    input wire logic           clock,
    input wire logic           nrst,
    input wire logic [4:0]     reg_addr,
    input wire logic           reg_rd,
    input wire logic [15:0]    reg_rdata,
    input wire logic           reg_rvalid,
    input wire logic           power_down_or_irq_pin_n,
    input wire logic           an_speed_100,
    input wire logic           an_full_duplex,
    input pbmc_pkg::pbmc_mii_s mii_tx,
    input pbmc_pkg::pbmc_mii_s mii_rx,
    input wire logic           mii_col,
    input wire logic           mii_oe,
    input pbmc_pkg::pbmc_mode_s mode
);
    import pbmc_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_loop;
        mode.loopback && !mode.isolate && !mode.power_down && !mode.core_reset;
    endsequence
    sequence s_pin;
        !power_down_or_irq_pin_n && !mode.core_reset;
    endsequence
    a_loop_echo: assert property (s_loop [*3] |-> mii_rx.data == $past(mii_tx.data))
        else $error("loopback data differs");
    a_pin_pdown: assert property (s_pin [*5] |-> mode.power_down)
        else $error("pin did not power down");
    a_iso_quiet: assert property (mode.isolate [*2] |-> !mii_oe && mii_rx == '0)
        else $error("isolated port drives");
    a_pdown_quiet: assert property (mode.power_down [*2] |-> mii_rx == '0 && !mii_col)
        else $error("powered down port active");
    a_aneg_follow: assert property (mode.aneg_enable |-> mode.speed_100 == $past(an_speed_100)
        && mode.full_duplex == $past(an_full_duplex))
        else $error("forced bits used under negotiation");
    a_restart_pulse: assert property (mode.aneg_restart |-> mode.aneg_enable ##1 !mode.aneg_restart)
        else $error("restart pulse wrong");
    a_rsvd_zero: assert property (reg_rvalid && $past(reg_addr) == 5'h00
        |-> reg_rdata[6:0] == 7'h00)
        else $error("reserved bits nonzero");
    a_stat_fixed: assert property (reg_rvalid && $past(reg_addr) == 5'h01
        |-> {reg_rdata[15:5], reg_rdata[3], reg_rdata[0]} == 13'h0F08)
        else $error("fixed status bits wrong");
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_dead_mask: assert property ($rose(mode.loopback) && DEAD_CYCLES >= 8
        |-> !mii_rx.en [*8])
        else $error("receive enable during dead time");
endmodule // pbmc_checker

bind pbmc_top pbmc_checker #(.DEAD_CYCLES(DEAD_CYCLES)) u_pbmc_checker (.clock, .nrst,
    .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .power_down_or_irq_pin_n, .an_speed_100,
    .an_full_duplex, .mii_tx, .mii_rx, .mii_col, .mii_oe, .mode);

// file: verif/pbmc_mac_model.sv
// Station manager model that issues whole-word register accesses
`timescale 1ns/10ps
module pbmc_mac_model (
    input  wire logic        clock,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid,
    output logic [4:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    initial
    begin
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] x);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        // Stale data would hide a late sample
        reg_wdata <= ~x;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] x, output logic ok);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        // Answer is registered and still stands at the next edge
        @(posedge clock);
        x = reg_rdata;
        ok = reg_rvalid;
    endtask
endmodule // pbmc_mac_model

// file: verif/test_pbmc_top.sv
// Self-checking bench for the basic mode control block
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_pbmc_top;
    import pbmc_pkg::*;
    logic        clock = 1'b0, nrst = 1'b0, reg_wr, reg_rd, reg_rvalid, mii_col, mii_oe;
    logic        strap_aneg = 1'b1, strap_speed = 1'b1, strap_duplex = 1'b0;
    logic        power_down_or_irq_pin_n = 1'b1, an_speed_100 = 1'b0, an_full_duplex = 1'b1;
    logic        link_ok = 1'b1, remote_fault = 1'b0, jabber = 1'b0, false_carrier = 1'b0;
    logic        line_col = 1'b0, v;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    pbmc_mii_s   mii_tx = '0, line_rx = 5'h15, mii_rx;
    pbmc_mode_s  mode;
    int          n_mismatch = 0, tests_run = 0, n_rst = 0;
    // Written word, read-back, expected {speed, duplex}
    localparam logic [15:0] ROWS [5][3] = '{'{16'h2100, 16'h2100, 16'h0003},
        '{16'h0000, 16'h0000, 16'h0000}, '{16'h207F, 16'h2000, 16'h0002},
        '{16'h1000, 16'h1000, 16'h0001}, '{16'h3100, 16'h3100, 16'h0001}};
    pbmc_top #(.DEAD_CYCLES(20)) u_pbmc_top (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .reg_rvalid, .strap_aneg, .strap_speed, .strap_duplex,
        .power_down_or_irq_pin_n, .an_speed_100, .an_full_duplex, .link_ok, .remote_fault,
        .jabber, .false_carrier, .mii_tx, .line_rx, .line_col, .mii_rx, .mii_col, .mii_oe, .mode);
    pbmc_mac_model u_pbmc_mac_model (.clock, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd);
    always #20 clock = ~clock;
    always @(posedge clock) if (mode.aneg_restart) n_rst <= n_rst + 1;
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic w(input logic [4:0] a, input logic [15:0] x);
        u_pbmc_mac_model.wr(a, x);
    endtask
    task automatic r(input logic [4:0] a, input logic [15:0] e);
        u_pbmc_mac_model.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask
    task automatic settle();
        int n;
        n = 0;
        d = 16'h8000;
        while (d[15] && n < 40)
        begin
            u_pbmc_mac_model.rd(5'h00, d, v);
            n++;
        end
        `CHK(d[15], 1'b0)
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        cyc(8);
        nrst <= 1'b1;
        settle();
        r(5'h00, 16'h3000);
        strap_aneg <= 1'b0;
        strap_speed <= 1'b0;
        strap_duplex <= 1'b1;
        w(5'h00, 16'h8000);
        u_pbmc_mac_model.rd(5'h00, d, v);
        `CHK(d[15], 1'b1)
        settle();
        r(5'h00, 16'h0100);
        $display("reset test done");
        for (int i = 0; i < 5; i++)
        begin
            w(5'h00, ROWS[i][0]);
            r(5'h00, ROWS[i][1]);
            `CHK({mode.speed_100, mode.full_duplex}, ROWS[i][2][1:0])
        end
        $display("table test done");
        w(5'h00, 16'h1200);
        cyc(3);
        `CHK(n_rst, 1)
        w(5'h00, 16'h0200);
        cyc(3);
        `CHK(n_rst, 1)
        r(5'h00, 16'h0000);
        mii_tx <= 5'h1A;
        w(5'h00, 16'h4000);
        cyc(4);
        `CHK(mii_rx.en, 1'b0)
        cyc(30);
        `CHK(mii_rx, 5'h1A)
        w(5'h00, 16'h0080);
        cyc(2);
        `CHK(mii_col, 1'b1)
        `CHK(mii_rx, 5'h15)
        mii_tx <= 5'h00;
        cyc(2);
        `CHK(mii_col, 1'b0)
        w(5'h00, 16'h0000);
        line_col <= 1'b1;
        cyc(2);
        `CHK(mii_col, 1'b1)
        line_col <= 1'b0;
        w(5'h00, 16'h0400);
        cyc(2);
        `CHK({mii_oe, mii_rx}, 6'h00)
        r(5'h00, 16'h0400);
        w(5'h00, 16'h0000);
        power_down_or_irq_pin_n <= 1'b0;
        cyc(6);
        r(5'h00, 16'h0800);
        `CHK(mode.power_down, 1'b1)
        power_down_or_irq_pin_n <= 1'b1;
        cyc(4);
        w(5'h00, 16'h0000);
        r(5'h00, 16'h0000);
        $display("control test done");
        u_pbmc_mac_model.rd(5'h01, d, v);
        r(5'h01, 16'h7844);
        remote_fault <= 1'b1;
        link_ok <= 1'b0;
        cyc(1);
        remote_fault <= 1'b0;
        link_ok <= 1'b1;
        cyc(2);
        r(5'h01, 16'h7850);
        r(5'h01, 16'h7844);
        jabber <= 1'b1;
        cyc(2);
        r(5'h01, 16'h7846);
        jabber <= 1'b0;
        cyc(2);
        r(5'h01, 16'h7844);
        w(5'h01, 16'hFFFF);
        r(5'h01, 16'h7844);
        repeat (3)
        begin
            false_carrier <= 1'b1;
            cyc(1);
            false_carrier <= 1'b0;
            cyc(1);
        end
        r(5'h14, 16'h0003);
        r(5'h14, 16'h0000);
        r(5'h05, 16'h0000);
        $display("status test done");
        nrst <= 1'b0;
        cyc(3);
        `CHK({mode, reg_rvalid, mii_oe}, 10'h004)
        nrst <= 1'b1;
        settle();
        r(5'h00, 16'h0100);
        $display("second reset test done");
        test_done();
    end
    initial
    begin
        cyc(4000);
        n_mismatch++;
        test_done();
    end
endmodule // test_pbmc_top
